// ===== hdl/swc_transceiver_ctrl.sv
`timescale 1ns/10ps
`include "swc_consts.svh"

// Summary of operation
// - Mode pins decode sleep, wake, high-speed, normal.
// - Low transmit input drives bus dominant.
// - Drive level and shaping follow decoded mode.
// - Undriven mode pins fall back to sleep.
// - Receive high recessive, low when dominant.
// - Sleep releases receive unless wake level seen.
// - Receive released after delay once wake ends.
// - Load switch closed unless ground lost.
// - Low ground-to-battery voltage means ground lost.
// - Wake level raises regulator enable output.
// - Regulator enable held 300 to 1000 ms.
// - Hold-off expiry with sleep pins forces sleep.
// - Internal delays timed by 500 kHz tick.
// - Driver kept enabled after recessive edge.
// - Wake detection deglitched before use.
// - High-volt only in wake mode; shaping below high-speed.
// - Undervoltage disables receiver and driver.
module swc_transceiver_ctrl #(
    parameter int unsigned HOLDOFF_TICKS = `SWC_HOLDOFF_TICKS,
    parameter int unsigned TX_HOLD_TICKS = `SWC_TX_HOLD_TICKS
) (
    // Clock and reset.
    input  wire logic             CORE_CLK,
    input  wire logic             RST,
    // Controller pins, already resolved against the weak pull-downs.
    input  wire logic             OP_SELECT_A,
    input  wire logic             OP_SELECT_B,
    input  wire logic             TX_DATA,
    // Receive open-drain pin.
    output logic                  RX_DATA_OUT,
    output logic                  RX_DATA_OE,
    // Analog front-end status.
    input  wire logic             BUS_DOMINANT,
    input  wire logic             HIGH_VOLT_WAKEUP_DETECT,
    input  wire logic             GROUND_LOST,
    input  wire logic             SUPPLY_UNDERVOLT,
    // Analog front-end controls.
    output swc_pkg::swc_drv_t     LINE_DRIVER,
    output logic                  LINE_RECEIVER_ENABLE,
    output logic                  LOAD_SWITCH_CLOSED,
    output logic                  REGULATOR_ENABLE_OUT,
    output swc_pkg::swc_mode_t    MODE
);
    import swc_pkg::*;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] next_sync1;

    always_comb begin
        next_sync1 = {OP_SELECT_A, OP_SELECT_B, TX_DATA, BUS_DOMINANT,
                      HIGH_VOLT_WAKEUP_DETECT, GROUND_LOST, SUPPLY_UNDERVOLT};
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sync1 <= 7'h10; // Mode pins low, transmit recessive.
            sync2 <= 7'h10;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end

    logic sel_a;
    logic sel_b;
    logic tx_s;
    logic dom_s;
    logic hv_raw;
    logic gnd_lost_s;
    logic uv_s;
    assign {sel_a, sel_b, tx_s, dom_s, hv_raw, gnd_lost_s, uv_s} = sync2;

    // ****************************************************************
    // 500 kHz tick divider.
    // ****************************************************************
    localparam int unsigned DIV = `SWC_OSC_DIV;
    logic [$clog2(DIV)-1:0] div_cnt;
    logic [$clog2(DIV)-1:0] next_div_cnt;
    logic                   tick;

    // One enable pulse every DIV core cycles stands in for the oscillator.
    always_comb begin
        tick         = (div_cnt == $bits(div_cnt)'(DIV - 1));
        next_div_cnt = tick ? '0 : div_cnt + 1'b1;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // ****************************************************************
    // Wake-level deglitch.
    // ****************************************************************
    logic [2:0] filt_cnt;
    logic [2:0] next_filt_cnt;
    logic       hv_wake;
    logic       next_hv_wake;

    // The level must hold for several ticks; one short spike cannot wake.
    always_comb begin
        next_filt_cnt = filt_cnt;
        next_hv_wake  = hv_wake;
        if (hv_raw == hv_wake) begin
            next_filt_cnt = '0;
        end else if (tick) begin
            if (filt_cnt == 3'(`SWC_WAKE_FILT_TICKS - 1)) begin
                next_hv_wake  = hv_raw;
                next_filt_cnt = '0;
            end else begin
                next_filt_cnt = filt_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            filt_cnt <= '0;
            hv_wake  <= 1'b0;
        end else begin
            filt_cnt <= next_filt_cnt;
            hv_wake  <= next_hv_wake;
        end
    end

    // ****************************************************************
    // Mode decode.
    // ****************************************************************
    function automatic swc_mode_t decode_mode(input logic a, input logic b);
        unique case ({a, b})
            `SWC_MODE_SLEEP:      decode_mode = SWC_SLEEP;
            `SWC_MODE_HV_WAKE:    decode_mode = SWC_HV_WAKE;
            `SWC_MODE_HIGH_SPEED: decode_mode = SWC_HIGH_SPEED;
            default:              decode_mode = SWC_NORMAL;
        endcase
    endfunction

    swc_mode_t pin_mode;
    logic      awake_req;
    assign pin_mode  = decode_mode(sel_a, sel_b);
    assign awake_req = (pin_mode != SWC_SLEEP);

    // ****************************************************************
    // Timers.
    // ****************************************************************
    logic hv_wake_q;
    logic wake_edge;
    logic holdoff_run;
    logic tx_hold_run;
    logic tx_q;
    logic tx_rise;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            hv_wake_q <= 1'b0;
            tx_q      <= 1'b1;
        end else begin
            hv_wake_q <= hv_wake;
            tx_q      <= tx_s;
        end
    end

    assign wake_edge = hv_wake & ~hv_wake_q;
    assign tx_rise   = tx_s & ~tx_q;

    // Hold-off reloads while the controller keeps a non-sleep mode or on a new wake.
    swc_tick_timer #(.WIDTH(20)) u_holdoff (
        .clk        (CORE_CLK),
        .rst        (RST),
        .tick       (tick),
        .restart    (awake_req | wake_edge),
        .load_value (20'(HOLDOFF_TICKS)),
        .running    (holdoff_run)
    );

    swc_tick_timer #(.WIDTH(8)) u_tx_hold (
        .clk        (CORE_CLK),
        .rst        (RST),
        .tick       (tick),
        .restart    (tx_rise),
        .load_value (8'(TX_HOLD_TICKS)),
        .running    (tx_hold_run)
    );

    // ****************************************************************
    // Regulator enable and awake state.
    // ****************************************************************
    logic awake;
    logic next_awake;

    // Expiry forces sleep even while the wake level stays on the bus.
    always_comb begin
        next_awake = awake;
        if (wake_edge || awake_req) begin
            next_awake = 1'b1;
        end else if (!holdoff_run) begin
            next_awake = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            awake <= 1'b0;
        end else begin
            awake <= next_awake;
        end
    end

    assign REGULATOR_ENABLE_OUT = awake;
    assign MODE = pin_mode;

    // ****************************************************************
    // Receive path.
    // ****************************************************************
    logic [2:0] rx_rel_cnt;
    logic [2:0] next_rx_rel_cnt;
    logic       rx_live;
    logic       next_rx_live;
    logic       next_rx_oe;
    logic       rx_oe;

    // In sleep only a wake level keeps the pin live; a selected mode cancels the tail.
    always_comb begin
        next_rx_live    = rx_live;
        next_rx_rel_cnt = rx_rel_cnt;
        if (hv_wake) begin
            next_rx_live    = 1'b1;
            next_rx_rel_cnt = '0;
        end else if (awake_req) begin
            next_rx_live    = 1'b0;
            next_rx_rel_cnt = '0;
        end else if (rx_live && tick) begin
            if (rx_rel_cnt == 3'(`SWC_RX_REL_TICKS - 1)) begin
                next_rx_live = 1'b0;
            end else begin
                next_rx_rel_cnt = rx_rel_cnt + 3'h1;
            end
        end
        next_rx_oe = (awake_req | next_rx_live) & ~uv_s & dom_s;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rx_live    <= 1'b0;
            rx_rel_cnt <= '0;
            rx_oe      <= 1'b0;
        end else begin
            rx_live    <= next_rx_live;
            rx_rel_cnt <= next_rx_rel_cnt;
            rx_oe      <= next_rx_oe;
        end
    end

    // Open-drain: only ever drives low.
    assign RX_DATA_OUT          = 1'b0;
    assign RX_DATA_OE           = rx_oe;
    assign LINE_RECEIVER_ENABLE = ~uv_s;

    // ****************************************************************
    // Driver and load switch.
    // ****************************************************************
    swc_drv_t drv;
    swc_drv_t next_drv;

    always_comb begin
        next_drv.drive_dominant = ~tx_s & ~uv_s;
        next_drv.drive_enable   = (~tx_s | tx_rise | tx_hold_run) & ~uv_s;
        next_drv.high_volt      = (pin_mode == SWC_HV_WAKE);
        next_drv.waveshape      = (pin_mode != SWC_HIGH_SPEED);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            drv                <= '0;
            LOAD_SWITCH_CLOSED <= 1'b0;
        end else begin
            drv                <= next_drv;
            LOAD_SWITCH_CLOSED <= ~gnd_lost_s;
        end
    end

    assign LINE_DRIVER = drv;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_load_switch_open: assert property (@(posedge CORE_CLK) disable iff (RST)
        $past(gnd_lost_s) |-> !LOAD_SWITCH_CLOSED)
        else $error("Load switch closed with ground lost.");

    a_tx_invert: assert property (@(posedge CORE_CLK) disable iff (RST)
        $past(tx_s) |-> !drv.drive_dominant)
        else $error("Dominant driven with transmit high.");

    a_uv_blank: assert property (@(posedge CORE_CLK) disable iff (RST)
        $past(uv_s) |-> !drv.drive_enable && !rx_oe)
        else $error("Driver or receiver active in undervoltage.");

    a_wake_regulator: assert property (@(posedge CORE_CLK) disable iff (RST)
        wake_edge |=> REGULATOR_ENABLE_OUT)
        else $error("Regulator enable not raised on wake.");

    a_awake_holds: assert property (@(posedge CORE_CLK) disable iff (RST)
        awake_req |=> REGULATOR_ENABLE_OUT [*2])
        else $error("Regulator enable dropped while awake requested.");

    a_speed_shape: assert property (@(posedge CORE_CLK) disable iff (RST)
        pin_mode == SWC_HIGH_SPEED |=> !drv.waveshape)
        else $error("Waveshaping in high-speed mode.");

    a_hv_mode: assert property (@(posedge CORE_CLK) disable iff (RST)
        pin_mode != SWC_HV_WAKE |=> !drv.high_volt)
        else $error("High-volt drive outside wake mode.");

    a_rx_sleep_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        !awake_req && !hv_wake && !rx_live |=> !RX_DATA_OE)
        else $error("Receive driven while released.");

    a_tx_hold_start: assert property (@(posedge CORE_CLK) disable iff (RST)
        tx_rise && !uv_s |=> drv.drive_enable)
        else $error("Driver enable dropped at recessive edge.");
endmodule

// ===== hdl/swc_consts.svh
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// ****************************************************************
// Mode pin encodings {op_select_a, op_select_b}.
// ****************************************************************
`define SWC_MODE_SLEEP      2'h0
`define SWC_MODE_HV_WAKE    2'h1
`define SWC_MODE_HIGH_SPEED 2'h2
`define SWC_MODE_NORMAL     2'h3

// ****************************************************************
// Timing figures.
// ****************************************************************
`define SWC_CORE_CLK_KHZ    250000
`define SWC_OSC_KHZ         500
`define SWC_OSC_DIV         (`SWC_CORE_CLK_KHZ / `SWC_OSC_KHZ)
`define SWC_HOLDOFF_MIN_MS  300
`define SWC_HOLDOFF_MAX_MS  1000
`define SWC_HOLDOFF_TICKS   (`SWC_HOLDOFF_MIN_MS * `SWC_OSC_KHZ)
`define SWC_TX_HOLD_TICKS   8
`define SWC_WAKE_FILT_TICKS 4
`define SWC_RX_REL_TICKS    4

`endif

// ===== hdl/swc_pkg.sv
package swc_pkg;
    typedef enum logic [3:0] {
        SWC_SLEEP      = 4'h1,
        SWC_HV_WAKE    = 4'h2,
        SWC_HIGH_SPEED = 4'h4,
        SWC_NORMAL     = 4'h8
    } swc_mode_t;

    // Bus driver controls toward the analog front end.
    typedef struct packed {
        logic drive_dominant;
        logic drive_enable;
        logic high_volt;
        logic waveshape;
    } swc_drv_t;
endpackage

// ===== hdl/swc_tick_timer.sv
`timescale 1ns/10ps
`include "swc_consts.svh"

// Down counter clocked by the oscillator tick; restart reloads it.
module swc_tick_timer #(
    parameter int unsigned WIDTH = 20
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Control.
    input  wire logic             tick,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] load_value,
    // Status.
    output logic                  running
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Restart takes priority so a new event always extends the hold.
    always_comb begin
        next_count = count;
        if (restart) begin
            next_count = load_value;
        end else if (tick && count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign running = (count != '0);
endmodule

// ===== verification/swc_mcu_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Controller model on the mode and transmit pins.
// ****************************************************************
module swc_mcu_model (
    // Clock.
    input  wire logic       clk,
    // Supply and requests from the bench.
    input  wire logic       ext_power,
    input  wire logic       regulator_on,
    input  wire logic [1:0] req_mode,
    input  wire logic       req_tx,
    // Pins toward the transceiver.
    output logic            op_a,
    output logic            op_b,
    output logic            tx
);
    int unsigned boot = 0;

    // The controller needs time to leave its own reset once powered.
    always @(posedge clk) begin
        boot <= regulator_on ? (boot < 250 ? boot + 1 : boot) : 0;
    end

    // Unpowered pins float, so the weak pull-downs win and read as sleep.
    always_comb begin
        if (ext_power || boot >= 250) begin
            {op_a, op_b} = req_mode;
            tx = req_tx;
        end else begin
            {op_a, op_b} = 2'h0;
            tx = 1'b1;
        end
    end
endmodule

// ===== verification/test_swc_transceiver_ctrl.sv
`timescale 1ns/10ps

// ****************************************************************
// Bench for the transceiver control block.
// ****************************************************************
module test_swc_transceiver_ctrl;
    import swc_pkg::*;
    // A short hold-off keeps the wake scenarios brief.
    localparam int unsigned HOLD = 20;
    localparam int          TICK = 500;
    logic       clk = 0, rst = 1, ext_power = 0, req_tx = 1;
    logic       bus_dom = 0, hv = 0, gnd_lost = 0, uv = 0;
    logic [1:0] req_mode = 2'h0;
    logic       op_a, op_b, tx, rx_out, rx_oe, rx_en, load_closed, reg_en;
    swc_drv_t   drv;
    swc_mode_t  mode;
    int         n_mismatch = 0;
    int         num_checks = 0;

    always #2 clk = ~clk;

    swc_transceiver_ctrl #(.HOLDOFF_TICKS(HOLD)) swc_transceiver_ctrl_i (
        .CORE_CLK(clk), .RST(rst), .OP_SELECT_A(op_a), .OP_SELECT_B(op_b),
        .TX_DATA(tx), .RX_DATA_OUT(rx_out), .RX_DATA_OE(rx_oe),
        .BUS_DOMINANT(bus_dom), .HIGH_VOLT_WAKEUP_DETECT(hv),
        .GROUND_LOST(gnd_lost), .SUPPLY_UNDERVOLT(uv), .LINE_DRIVER(drv),
        .LINE_RECEIVER_ENABLE(rx_en), .LOAD_SWITCH_CLOSED(load_closed),
        .REGULATOR_ENABLE_OUT(reg_en), .MODE(mode));

    swc_mcu_model swc_mcu_model_i (
        .clk(clk), .ext_power(ext_power), .regulator_on(reg_en),
        .req_mode(req_mode), .req_tx(req_tx), .op_a(op_a), .op_b(op_b), .tx(tx));

    // ****************************************************************
    // Shared helpers.
    // ****************************************************************
    task check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task test_done;
        $display("mismatches %0d, checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic pick(input int s);
        return s == 0 ? reg_en : (s == 1 ? drv.drive_enable : rx_oe);
    endfunction

    // Bounded wait; a level that never comes ends the run as a failure.
    task wait_on(input int sel, input logic v, input int n);
        int i;
        for (i = 0; i < n && pick(sel) !== v; i++) @(posedge clk);
        if (pick(sel) !== v) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: wait on %0d timed out", $time, sel);
            test_done();
        end
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task sc_modes;
        swc_mode_t om [4] = '{SWC_SLEEP, SWC_HV_WAKE, SWC_HIGH_SPEED, SWC_NORMAL};
        @(posedge clk);
        ext_power <= 1'b1;
        req_tx    <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            req_mode <= m[1:0];
            cyc(6);
            check(mode, om[m]);
            if (m != 0) check({drv.drive_dominant, drv.high_volt, drv.waveshape},
                              {1'b1, m == 1, m != 2});
        end
    endtask

    // Release ends the dominant drive; the driver stays enabled for the hold, then drops.
    task sc_tx_hold;
        @(posedge clk);
        req_tx <= 1'b1;
        cyc(5);
        check(drv.drive_dominant, 1'b0);
        check(drv.drive_enable, 1'b1);
        cyc(6 * TICK);
        check(drv.drive_enable, 1'b1);
        wait_on(1, 1'b0, 3 * TICK);
    endtask

    task sc_rx;
        @(posedge clk);
        bus_dom <= 1'b1;
        cyc(5);
        check({rx_oe, rx_out}, 2'h2);
        bus_dom <= 1'b0;
        cyc(5);
        check(rx_oe, 1'b0);
        req_mode <= 2'h0;
        bus_dom  <= 1'b1;
        cyc(6);
        check(rx_oe, 1'b0);
        bus_dom <= 1'b0;
    endtask

    task sc_faults;
        @(posedge clk);
        req_mode <= 2'h3;
        req_tx   <= 1'b0;
        cyc(6);
        check(load_closed, 1'b1);
        gnd_lost <= 1'b1;
        cyc(5);
        check(load_closed, 1'b0);
        gnd_lost <= 1'b0;
        uv       <= 1'b1;
        bus_dom  <= 1'b1;
        cyc(5);
        check({rx_en, drv.drive_enable, rx_oe}, 3'h0);
        uv      <= 1'b0;
        bus_dom <= 1'b0;
        req_tx  <= 1'b1;
        cyc(5);
        check(rx_en, 1'b1);
    endtask

    // The controller leaves sleep selected, so the hold-off runs out under wake.
    task sc_wake_timeout;
        @(posedge clk);
        ext_power <= 1'b0;
        req_mode  <= 2'h0;
        wait_on(0, 1'b0, 25 * TICK);
        hv        <= 1'b1;
        cyc(TICK * 3 / 2);
        hv <= 1'b0;
        cyc(3 * TICK);
        check(reg_en, 1'b0);
        hv      <= 1'b1;
        bus_dom <= 1'b1;
        wait_on(0, 1'b1, 6 * TICK);
        cyc(5);
        check(rx_oe, 1'b1);
        cyc(12 * TICK);
        check(reg_en, 1'b1);
        wait_on(0, 1'b0, 12 * TICK);
        hv <= 1'b0;
        wait_on(2, 1'b0, 10 * TICK);
        bus_dom <= 1'b0;
    endtask

    // The controller boots and selects normal mode, keeping power on.
    task sc_wake_kept;
        @(posedge clk);
        req_mode <= 2'h3;
        hv       <= 1'b1;
        wait_on(0, 1'b1, 6 * TICK);
        hv <= 1'b0;
        cyc(30 * TICK);
        check(reg_en, 1'b1);
        check(mode, SWC_NORMAL);
        req_mode <= 2'h0;
        wait_on(0, 1'b0, 25 * TICK);
    endtask

    initial begin
        cyc(4);
        check(mode, SWC_SLEEP);
        rst <= 1'b0;
        cyc(3);
        sc_modes();
        sc_tx_hold();
        sc_rx();
        sc_faults();
        sc_wake_timeout();
        sc_wake_kept();
        test_done();
    end
endmodule
